// ===== common/eeprom_pkg.sv
// shared constants and types of the two-wire serial eeprom link
package eeprom_pkg;

    // ==========================================================
    // device type codes and address layout
    localparam logic [3:0] TYPE_MAIN = 4'hA;
    localparam logic [3:0] TYPE_ID = 4'hB;
    localparam int ADDR_W = 14;
    localparam int PAGE_W = 6;
    localparam int PAGE_BYTES = 64;
    localparam int LOCK_SEL_BIT = 10;
    localparam int LOCK_DATA_BIT = 1;
    localparam logic [7:0] LOCK_DATA = 8'h02;
    localparam logic [2:0] CS_RESET = 3'h0;

    // ==========================================================
    // timing
    localparam int CLK_NS = 8;
    localparam int WRITE_CYCLE_NS = 3000000;
    // longest time, so rounded down
    localparam int WR_CYCLES = WRITE_CYCLE_NS / CLK_NS;
    localparam int SCL_PERIOD_NS = 1000;
    // least time, so rounded up
    localparam int QUARTER_CYCLES = (SCL_PERIOD_NS / 4 + CLK_NS - 1) / CLK_NS;

    // ==========================================================
    // host command codes
    typedef enum logic [2:0] {
        OP_WRITE = 3'h0,
        OP_READ = 3'h1,
        OP_CURREAD = 3'h2,
        OP_IDWRITE = 3'h3,
        OP_IDREAD = 3'h4,
        OP_LOCK = 3'h5
    } op_t;

endpackage

// ===== common/eeprom_link_if.sv
// two-wire link between the eeprom and its bus master
`timescale 1ns/1ps
`default_nettype none
interface eeprom_link_if;
    logic scl;
    logic sda;
    logic devSdaOut;
    logic devSdaOe;
    logic hostSdaOut;
    logic hostSdaOe;

    // open-drain line with a pull-up: any enabled low driver wins
    assign sda = ~((devSdaOe & ~devSdaOut) | (hostSdaOe & ~hostSdaOut));

    modport device(input scl, input sda, output devSdaOut, output devSdaOe);
    modport host(output scl, input sda, output hostSdaOut, output hostSdaOe);
endinterface
`default_nettype wire

// ===== src/eeprom_host.sv
// bus master end: turns user commands into two-wire transfers
`timescale 1ns/1ps
`default_nettype none
module eeprom_host
    import eeprom_pkg::*;
#(
    parameter int QUARTER = QUARTER_CYCLES
) (
    // clock and reset
    input wire logic clock,
    input wire logic srst,
    // two-wire link
    eeprom_link_if.host link,
    // command port
    input wire logic cmdValid,
    input wire op_t cmdOp,
    input wire logic [2:0] cmdChip,
    input wire logic [15:0] cmdAddr,
    input wire logic [6:0] cmdLen,
    output logic cmdReady,
    // write data, consumed on wrTake
    input wire logic [7:0] wrData,
    output logic wrTake,
    // read data and completion
    output logic [7:0] rdData,
    output logic rdValid,
    output logic done,
    output logic nack
);
    localparam int QW = $clog2(QUARTER + 1);

    typedef enum logic [3:0] {
        H_IDLE = 4'h0, H_START = 4'h1, H_DEV = 4'h3, H_AHI = 4'h2,
        H_ALO = 4'h6, H_WDAT = 4'h7, H_RSTART = 4'h5, H_RDEV = 4'h4,
        H_RDAT = 4'hC, H_STOP = 4'hD
    } host_state_t;

    typedef struct packed {
        host_state_t st;
        logic [QW-1:0] tick;
        logic [1:0] q;
        logic [3:0] bitIdx;
        logic [7:0] tx;
        logic [7:0] rx;
        logic ackBit;
        op_t op;
        logic [2:0] chip;
        logic [15:0] addr;
        logic [6:0] rem;
        logic sdaOe;
        logic sclO;
        logic sdaS1;
        logic sdaS2;
        logic nack;
        logic done;
        logic [7:0] rdData;
        logic rdValid;
        logic wrTake;
        logic ready;
    } host_regs_t;

    host_regs_t s_r;
    host_regs_t s_nxt;
    logic isTx;
    logic isRd;

    // device address byte: type code, chip select, direction
    function automatic logic [7:0] devByte(input op_t op, input logic [2:0] cs, input logic rd);
        devByte = {(op == OP_IDWRITE || op == OP_IDREAD || op == OP_LOCK) ? TYPE_ID : TYPE_MAIN, cs, rd};
    endfunction

    // each symbol is four quarter ticks: set data, raise, sample, lower
    always_comb begin
        s_nxt = s_r;
        s_nxt.sdaS1 = link.sda;
        s_nxt.sdaS2 = s_r.sdaS1;
        s_nxt.done = 1'b0;
        s_nxt.rdValid = 1'b0;
        s_nxt.wrTake = 1'b0;
        s_nxt.tick = s_r.tick + 1'b1;
        isTx = s_r.st != H_RDAT;
        isRd = s_r.op == OP_READ || s_r.op == OP_IDREAD;
        if (s_r.st == H_IDLE) begin
            s_nxt.tick = '0;
            s_nxt.q = 2'h0;
            s_nxt.ready = 1'b1;
            if (cmdValid && s_r.ready) begin
                s_nxt.ready = 1'b0;
                s_nxt.nack = 1'b0;
                s_nxt.op = cmdOp;
                s_nxt.chip = cmdChip;
                s_nxt.addr = cmdAddr;
                s_nxt.rem = (cmdOp == OP_LOCK || cmdLen == 7'h00) ? 7'h01 : cmdLen;
                if (cmdOp == OP_IDWRITE) s_nxt.addr[LOCK_SEL_BIT] = 1'b0;
                if (cmdOp == OP_LOCK) s_nxt.addr[LOCK_SEL_BIT] = 1'b1;
                s_nxt.st = H_START;
            end
        end else if (s_r.tick == QW'(QUARTER - 1)) begin
            s_nxt.tick = '0;
            s_nxt.q = s_r.q + 2'h1;
            unique case (s_r.q)
                2'h0: begin
                    if (s_r.st == H_START || s_r.st == H_RSTART) s_nxt.sdaOe = 1'b0;
                    else if (s_r.st == H_STOP) s_nxt.sdaOe = 1'b1;
                    else if (s_r.bitIdx == 4'h8) s_nxt.sdaOe = !isTx && s_r.rem != 7'h01;
                    else s_nxt.sdaOe = isTx && !s_r.tx[3'h7 - s_r.bitIdx[2:0]];
                end
                2'h1: s_nxt.sclO = 1'b1;
                2'h2: begin
                    if (s_r.st == H_START || s_r.st == H_RSTART) s_nxt.sdaOe = 1'b1;
                    else if (s_r.st == H_STOP) s_nxt.sdaOe = 1'b0;
                    else if (s_r.bitIdx == 4'h8) s_nxt.ackBit = s_r.sdaS2;
                    else s_nxt.rx = {s_r.rx[6:0], s_r.sdaS2};
                end
                2'h3: begin
                    if (s_r.st == H_STOP) begin
                        s_nxt.st = H_IDLE;
                        s_nxt.done = 1'b1;
                    end else begin
                        s_nxt.sclO = 1'b0;
                        s_nxt.bitIdx = s_r.bitIdx + 4'h1;
                        if (s_r.st == H_START) begin
                            s_nxt.st = H_DEV;
                            s_nxt.tx = devByte(s_r.op, s_r.chip, s_r.op == OP_CURREAD);
                            s_nxt.bitIdx = 4'h0;
                        end else if (s_r.st == H_RSTART) begin
                            s_nxt.st = H_RDEV;
                            s_nxt.tx = devByte(s_r.op, s_r.chip, 1'b1);
                            s_nxt.bitIdx = 4'h0;
                        end else if (s_r.bitIdx == 4'h8) begin
                            // byte finished: pick the next field of the frame
                            s_nxt.bitIdx = 4'h0;
                            if (isTx && s_r.ackBit) begin
                                // a refused device byte is how a busy part answers a poll
                                s_nxt.nack = 1'b1;
                                s_nxt.st = H_STOP;
                            end else begin
                                unique case (s_r.st)
                                    H_DEV: begin
                                        s_nxt.st = (s_r.op == OP_CURREAD) ? H_RDAT : H_AHI;
                                        s_nxt.tx = s_r.addr[15:8];
                                    end
                                    H_AHI: begin
                                        s_nxt.st = H_ALO;
                                        s_nxt.tx = s_r.addr[7:0];
                                    end
                                    H_ALO: begin
                                        s_nxt.st = isRd ? H_RSTART : H_WDAT;
                                        s_nxt.tx = (s_r.op == OP_LOCK) ? LOCK_DATA : wrData;
                                        s_nxt.wrTake = !isRd && s_r.op != OP_LOCK;
                                    end
                                    H_WDAT: begin
                                        s_nxt.rem = s_r.rem - 7'h01;
                                        s_nxt.st = (s_r.rem == 7'h01) ? H_STOP : H_WDAT;
                                        s_nxt.tx = wrData;
                                        s_nxt.wrTake = s_r.rem != 7'h01;
                                    end
                                    H_RDEV: s_nxt.st = H_RDAT;
                                    H_RDAT: begin
                                        s_nxt.rdData = s_r.rx;
                                        s_nxt.rdValid = 1'b1;
                                        s_nxt.rem = s_r.rem - 7'h01;
                                        s_nxt.st = (s_r.rem == 7'h01) ? H_STOP : H_RDAT;
                                    end
                                    default: s_nxt.st = H_STOP;
                                endcase
                            end
                        end
                    end
                end
            endcase
        end
    end

    // state register; idle link is both lines high
    always_ff @(posedge clock) begin
        if (srst) begin
            s_r <= '0;
            s_r.st <= H_IDLE;
            s_r.op <= OP_WRITE;
            s_r.sclO <= 1'b1;
            s_r.sdaS1 <= 1'b1;
            s_r.sdaS2 <= 1'b1;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign link.scl = s_r.sclO;
    assign link.hostSdaOut = 1'b0;
    assign link.hostSdaOe = s_r.sdaOe;
    assign cmdReady = s_r.ready;
    assign wrTake = s_r.wrTake;
    assign rdData = s_r.rdData;
    assign rdValid = s_r.rdValid;
    assign done = s_r.done;
    assign nack = s_r.nack;
endmodule
`default_nettype wire

// ===== src/eeprom_device.sv
// memory end of the two-wire serial eeprom link
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - master sends two address bytes, high first
// - acknowledge each address byte, then take data
// - stop after last data starts programming
// - programming ignores bus and gives no acknowledge
// - page write carries up to 64 bytes
// - acknowledge every page write data byte except to a locked id page
// - data bytes advance only low six address bits
// - id page write: type 1011b, select bit zero
// - locked id page: data refused, page kept
// - device byte acknowledged only after programming
// - read sets direction bit to one
// - address counter holds last address plus one
// - reads wrap from last byte to first
// - current read sends byte at counter
// - random read: dummy write, repeated start, read
// - master acknowledge continues sequential read
// - id page read uses low six bits
// - lock: type 1011b, select one, data bit1
// - programming timed from stop to completion
// - chip select mismatch returns to standby silently
// - fourteen-bit word address over whole array
// - write lock input protects main array
module eeprom_device
    import eeprom_pkg::*;
#(
    parameter int WRITE_CYCLES = WR_CYCLES
) (
    // clock and reset
    input wire logic clock,
    input wire logic srst,
    // two-wire link
    eeprom_link_if.device link,
    // straps and status
    input wire logic [2:0] chipSel,
    input wire logic writeLock,
    output logic busy,
    output logic idLocked
);
    localparam int TW = $clog2(WRITE_CYCLES + 1);

    typedef enum logic [2:0] {
        D_IDLE = 3'h0, D_DEV = 3'h1, D_AHI = 3'h3, D_ALO = 3'h2,
        D_WDAT = 3'h6, D_RDAT = 3'h7, D_BUSY = 3'h5
    } dev_state_t;

    typedef struct packed {
        dev_state_t st;
        logic sclS1;
        logic sclS2;
        logic sclLast;
        logic sdaS1;
        logic sdaS2;
        logic sdaLast;
        logic wlS1;
        logic wlS2;
        logic [2:0] csS1;
        logic [2:0] csS2;
        logic [3:0] bitCnt;
        logic [7:0] shift;
        logic [7:0] outByte;
        logic ackNow;
        logic sdaOe;
        logic isId;
        logic lockSel;
        logic [ADDR_W-1:0] addr;
        logic [PAGE_W-1:0] idOff;
        logic [PAGE_BYTES-1:0] mask;
        logic lockReq;
        logic locked;
        logic [TW-1:0] timer;
        logic busyO;
    } dev_regs_t;

    dev_regs_t s_r;
    dev_regs_t s_nxt;

    // arrays: main store, id page, and the page latch filled during a frame
    logic [7:0] mainMem [0:(1 << ADDR_W) - 1];
    logic [7:0] idMem [0:PAGE_BYTES - 1];
    logic [7:0] pageBuf [0:PAGE_BYTES - 1];

    logic sclRise;
    logic sclFall;
    logic startSeen;
    logic stopSeen;
    logic [7:0] rxByte;
    logic bufWe;
    logic [PAGE_W-1:0] bufIdx;
    logic commitWe;
    logic [PAGE_W-1:0] commitIdx;

    // line events, all taken from the second synchroniser stage
    assign sclRise = s_r.sclS2 & ~s_r.sclLast;
    assign sclFall = ~s_r.sclS2 & s_r.sclLast;
    assign startSeen = s_r.sclS2 & s_r.sclLast & s_r.sdaLast & ~s_r.sdaS2;
    assign stopSeen = s_r.sclS2 & s_r.sclLast & ~s_r.sdaLast & s_r.sdaS2;
    assign rxByte = {s_r.shift[6:0], s_r.sdaS2};
    assign commitIdx = s_r.timer[PAGE_W-1:0];

    // protocol engine: bits in on rising scl, bits out on falling scl
    always_comb begin
        s_nxt = s_r;
        bufWe = 1'b0;
        bufIdx = s_r.addr[PAGE_W-1:0];
        commitWe = 1'b0;
        s_nxt.sclS1 = link.scl;
        s_nxt.sclS2 = s_r.sclS1;
        s_nxt.sclLast = s_r.sclS2;
        s_nxt.sdaS1 = link.sda;
        s_nxt.sdaS2 = s_r.sdaS1;
        s_nxt.sdaLast = s_r.sdaS2;
        s_nxt.wlS1 = writeLock;
        s_nxt.wlS2 = s_r.wlS1;
        s_nxt.csS1 = chipSel;
        s_nxt.csS2 = s_r.csS1;
        if (s_r.st == D_BUSY) begin
            // the page latch drains one byte a cycle at the start of the cycle
            s_nxt.timer = s_r.timer + 1'b1;
            commitWe = s_r.timer < TW'(PAGE_BYTES) && s_r.mask[commitIdx];
            if (s_r.timer == TW'(WRITE_CYCLES - 1)) begin
                s_nxt.st = D_IDLE;
                s_nxt.locked = s_r.locked | s_r.lockReq;
                s_nxt.lockReq = 1'b0;
                s_nxt.mask = '0;
            end
        end else if (s_r.st != D_IDLE && sclRise) begin
            if (s_r.bitCnt != 4'h8) begin
                s_nxt.shift = rxByte;
                s_nxt.bitCnt = s_r.bitCnt + 4'h1;
            end
            if (s_r.bitCnt == 4'h7 && s_r.st != D_RDAT) begin
                // whole byte in: decide the acknowledge now
                s_nxt.ackNow = 1'b0;
                unique case (s_r.st)
                    D_DEV: begin
                        if ((rxByte[7:4] == TYPE_MAIN || rxByte[7:4] == TYPE_ID) && rxByte[3:1] == s_r.csS2) begin
                            s_nxt.ackNow = 1'b1;
                            s_nxt.isId = rxByte[7:4] == TYPE_ID;
                            s_nxt.st = rxByte[0] ? D_RDAT : D_AHI;
                        end else begin
                            s_nxt.st = D_IDLE;
                        end
                    end
                    D_AHI: begin
                        s_nxt.ackNow = 1'b1;
                        s_nxt.addr[ADDR_W-1:8] = rxByte[ADDR_W-9:0];
                        s_nxt.lockSel = rxByte[LOCK_SEL_BIT - 8];
                        s_nxt.st = D_ALO;
                    end
                    D_ALO: begin
                        s_nxt.ackNow = 1'b1;
                        s_nxt.addr[7:0] = rxByte;
                        s_nxt.idOff = rxByte[PAGE_W-1:0];
                        s_nxt.mask = '0;
                        s_nxt.lockReq = 1'b0;
                        s_nxt.st = D_WDAT;
                    end
                    D_WDAT: begin
                        if (s_r.isId && s_r.lockSel) begin
                            s_nxt.ackNow = ~s_r.locked;
                            s_nxt.lockReq = ~s_r.locked & rxByte[LOCK_DATA_BIT];
                        end else if (s_r.isId) begin
                            if (!s_r.locked) begin
                                s_nxt.ackNow = 1'b1;
                                bufWe = 1'b1;
                                bufIdx = s_r.idOff;
                                s_nxt.mask[s_r.idOff] = 1'b1;
                                s_nxt.idOff = s_r.idOff + 1'b1;
                            end
                        end else begin
                            s_nxt.ackNow = 1'b1;
                            bufWe = ~s_r.wlS2;
                            s_nxt.mask[s_r.addr[PAGE_W-1:0]] = s_r.mask[s_r.addr[PAGE_W-1:0]] | ~s_r.wlS2;
                            s_nxt.addr[PAGE_W-1:0] = s_r.addr[PAGE_W-1:0] + 1'b1;
                        end
                    end
                    default: ;
                endcase
            end else if (s_r.bitCnt == 4'h8) begin
                // ninth clock: ours was an acknowledge, or the master answers
                s_nxt.bitCnt = 4'h0;
                s_nxt.ackNow = 1'b0;
                if (s_r.st == D_RDAT && !s_r.ackNow) begin
                    s_nxt.addr = s_r.addr + 1'b1;
                    s_nxt.idOff = s_r.idOff + 1'b1;
                    if (s_r.sdaS2) s_nxt.st = D_IDLE;
                end
                s_nxt.outByte = s_r.isId ? idMem[s_nxt.idOff] : mainMem[s_nxt.addr];
            end
        end
        if (s_r.st != D_BUSY && sclFall) begin
            if (s_r.bitCnt == 4'h8) s_nxt.sdaOe = s_r.ackNow;
            else if (s_r.st == D_RDAT) s_nxt.sdaOe = ~s_r.outByte[3'h7 - s_r.bitCnt[2:0]];
            else s_nxt.sdaOe = 1'b0;
        end
        // start and stop override bit handling; the busy state ignores both
        if (s_r.st != D_BUSY && startSeen) begin
            s_nxt.st = D_DEV;
            s_nxt.bitCnt = 4'h0;
            s_nxt.ackNow = 1'b0;
            s_nxt.sdaOe = 1'b0;
        end else if (s_r.st != D_BUSY && stopSeen) begin
            s_nxt.sdaOe = 1'b0;
            s_nxt.ackNow = 1'b0;
            s_nxt.bitCnt = 4'h0;
            s_nxt.timer = '0;
            s_nxt.st = (s_r.st == D_WDAT && (s_r.mask != '0 || s_r.lockReq)) ? D_BUSY : D_IDLE;
        end
        s_nxt.busyO = s_nxt.st == D_BUSY;
    end

    // state register; the lock bit models a blank part at reset
    always_ff @(posedge clock) begin
        if (srst) begin
            s_r <= '0;
            s_r.st <= D_IDLE;
            s_r.sclS1 <= 1'b1;
            s_r.sclS2 <= 1'b1;
            s_r.sclLast <= 1'b1;
            s_r.sdaS1 <= 1'b1;
            s_r.sdaS2 <= 1'b1;
            s_r.sdaLast <= 1'b1;
            s_r.csS1 <= CS_RESET;
            s_r.csS2 <= CS_RESET;
        end else begin
            s_r <= s_nxt;
        end
    end

    // arrays: no reset, contents persist like the cells they stand for
    always_ff @(posedge clock) begin
        if (bufWe) begin
            pageBuf[bufIdx] <= rxByte;
        end
        if (commitWe && !s_r.isId) begin
            mainMem[{s_r.addr[ADDR_W-1:PAGE_W], commitIdx}] <= pageBuf[commitIdx];
        end
        if (commitWe && s_r.isId) begin
            idMem[commitIdx] <= pageBuf[commitIdx];
        end
    end

    assign link.devSdaOut = 1'b0;
    assign link.devSdaOe = s_r.sdaOe;
    assign busy = s_r.busyO;
    assign idLocked = s_r.locked;
endmodule
`default_nettype wire

// ===== verif/eeprom_link_props.sv
// concurrent checks on the two-wire eeprom link and device status
`timescale 1ns/1ps
`default_nettype none
module eeprom_link_props #(
    parameter int WRITE_CYCLES = 200
) (
    // clock and reset
    input wire logic clock,
    input wire logic srst,
    // two-wire link
    input wire logic scl,
    input wire logic sda,
    input wire logic devSdaOe,
    // device status
    input wire logic busy,
    input wire logic idLocked
);
    // ==========================================================
    // helper logic
    logic [31:0] busyCnt_r;

    // length of the running programming cycle; too long for a repetition
    always_ff @(posedge clock) begin
        if (srst || !busy) begin
            busyCnt_r <= '0;
        end else begin
            busyCnt_r <= busyCnt_r + 32'h1;
        end
    end

    // ==========================================================
    // properties
    default clocking cb @(posedge clock); endclocking
    default disable iff (srst);

    sequence busyRun;
        busy [*8];
    endsequence

    sequence busIdleHigh;
        scl && sda;
    endsequence

    AST_NO_ACK_BUSY: assert property (busy |-> !devSdaOe)
        else $error("device drives sda while programming");
    AST_BUSY_LEN: assert property ($fell(busy) |-> busyCnt_r >= WRITE_CYCLES - 2 && busyCnt_r <= WRITE_CYCLES + 1)
        else $error("programming cycle length wrong");
    AST_BUSY_FROM_STOP: assert property ($rose(busy) |-> busIdleHigh)
        else $error("programming started without a stop");
    AST_BUSY_HOLD: assert property ($rose(busy) |-> busyRun)
        else $error("programming cycle cut short");
    AST_DEV_CHANGE_LOW: assert property ($changed(devSdaOe) |-> !scl)
        else $error("device changed sda while scl high");
    AST_DEV_STABLE_HIGH: assert property (scl && $past(scl) |-> $stable(devSdaOe))
        else $error("device drive moved during scl high");
    AST_IDLOCK_STICKY: assert property (idLocked |=> idLocked)
        else $error("id page lock was lost");
    AST_IDLOCK_AT_END: assert property ($rose(idLocked) |-> $fell(busy))
        else $error("id page lock not tied to end of programming");
endmodule
`default_nettype wire

// ===== verif/test_serial_eeprom_access_protocol.sv
// self-checking bench: host and device ends joined over the link
`timescale 1ns/1ps
`default_nettype none
module test_serial_eeprom_access_protocol;
    import eeprom_pkg::*;
    // ==========================================================
    // signals
    logic clock = 1'b0;
    logic srst = 1'b1;
    logic cmdValid = 1'b0;
    op_t cmdOp = OP_WRITE;
    logic [2:0] cmdChip = 3'h5;
    logic [15:0] cmdAddr = 16'h0000;
    logic [6:0] cmdLen = 7'h01;
    logic cmdReady, wrTake, rdValid, done, nack, busy, idLocked;
    logic [7:0] wrData = 8'h00;
    logic [7:0] rdData;
    logic [2:0] chipSel = 3'h5;
    logic writeLock = 1'b0;
    logic [7:0] wrBuf [0:63];
    logic [7:0] rdBuf [0:63];
    int wrIdx = 0;
    int rdIdx = 0;
    int failCount = 0;
    int checksDone = 0;

    // 8 ns clock
    always #4 clock = ~clock;

    eeprom_link_if linkIf();
    eeprom_host #(.QUARTER(8)) eeprom_host_i (.clock(clock), .srst(srst), .link(linkIf), .cmdValid(cmdValid),
        .cmdOp(cmdOp), .cmdChip(cmdChip), .cmdAddr(cmdAddr), .cmdLen(cmdLen), .cmdReady(cmdReady), .wrData(wrData),
        .wrTake(wrTake), .rdData(rdData), .rdValid(rdValid), .done(done), .nack(nack));
    // short programming time keeps the run brief
    eeprom_device #(.WRITE_CYCLES(200)) eeprom_device_i (.clock(clock), .srst(srst), .link(linkIf),
        .chipSel(chipSel), .writeLock(writeLock), .busy(busy), .idLocked(idLocked));
    eeprom_link_props #(.WRITE_CYCLES(200)) eeprom_link_props_i (.clock(clock), .srst(srst), .scl(linkIf.scl),
        .sda(linkIf.sda), .devSdaOe(linkIf.devSdaOe), .busy(busy), .idLocked(idLocked));

    // feed write bytes on each take and collect read bytes
    always @(negedge clock) begin
        if (wrTake === 1'b1) wrIdx = wrIdx + 1;
        wrData = wrBuf[wrIdx];
        if (rdValid === 1'b1) begin
            rdBuf[rdIdx] = rdData;
            rdIdx = rdIdx + 1;
        end
    end

    // ==========================================================
    // tasks
    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        checksDone++;
        if (got !== exp) begin
            failCount++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic close_out();
        $display("checks %0d mismatches %0d", checksDone, failCount);
        if (failCount == 0 && checksDone > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    // one whole frame: wait for ready, raise the request for one cycle, then wait for done
    task automatic cmd(input op_t op, input logic [2:0] chip, input logic [15:0] addr, input logic [6:0] len);
        int n;
        n = 0;
        while (cmdReady !== 1'b1 && n < 1000) begin
            @(negedge clock);
            n++;
        end
        wrIdx = 0;
        rdIdx = 0;
        cmdOp = op;
        cmdChip = chip;
        cmdAddr = addr;
        cmdLen = len;
        cmdValid = 1'b1;
        @(negedge clock);
        cmdValid = 1'b0;
        n = 0;
        while (done !== 1'b1 && n < 20000) begin
            @(negedge clock);
            n++;
        end
        if (n >= 20000) check("done", 16'h1, 16'h0);
    endtask

    // let a programming cycle run out before the next access
    task automatic waitIdle();
        int n;
        n = 0;
        repeat (8) @(negedge clock);
        while (busy !== 1'b0 && n < 1000) begin
            @(negedge clock);
            n++;
        end
    endtask

    // ==========================================================
    // watchdog: tests need about 30000 cycles, so allow twice that
    initial begin
        #480000;
        failCount++;
        close_out();
    end

    initial begin
        repeat (12) @(negedge clock);
        srst = 1'b0;
        repeat (4) @(negedge clock);
        // page write, poll while programming, read back
        for (int i = 0; i < 3; i++) wrBuf[i] = 8'(8'h11 * (i + 1));
        cmd(OP_WRITE, 3'h5, 16'h0140, 7'h03);
        check("write nack", 16'h0, {15'h0, nack});
        cmd(OP_CURREAD, 3'h5, 16'h0000, 7'h01);
        check("poll nack", 16'h1, {15'h0, nack});
        // the refused poll outlasts the short programming time, so this retry is answered
        cmd(OP_READ, 3'h5, 16'h0140, 7'h03);
        check("poll ack", 16'h0, {15'h0, nack});
        for (int i = 0; i < 3; i++) check("page byte", 16'(8'h11 * (i + 1)), {8'h0, rdBuf[i]});
        cmd(OP_READ, 3'h5, 16'h0140, 7'h02);
        cmd(OP_CURREAD, 3'h5, 16'h0000, 7'h01);
        check("current read", 16'h0033, {8'h0, rdBuf[0]});
        $display("test page write done");
        // page wrap on write
        wrBuf[0] = 8'hAA;
        wrBuf[1] = 8'hBB;
        cmd(OP_WRITE, 3'h5, 16'h017F, 7'h02);
        waitIdle();
        cmd(OP_READ, 3'h5, 16'h017F, 7'h01);
        check("page end", 16'h00AA, {8'h0, rdBuf[0]});
        cmd(OP_READ, 3'h5, 16'h0140, 7'h01);
        check("page wrap", 16'h00BB, {8'h0, rdBuf[0]});
        $display("test page wrap done");
        // array rollover on sequential read, high address bits ignored
        wrBuf[0] = 8'hC1;
        cmd(OP_WRITE, 3'h5, 16'h3FFF, 7'h01);
        waitIdle();
        wrBuf[0] = 8'hC2;
        cmd(OP_WRITE, 3'h5, 16'h0000, 7'h01);
        waitIdle();
        cmd(OP_READ, 3'h5, 16'hFFFF, 7'h02);
        check("last byte", 16'h00C1, {8'h0, rdBuf[0]});
        check("rollover", 16'h00C2, {8'h0, rdBuf[1]});
        $display("test rollover done");
        // chip select mismatch and write lock
        cmd(OP_READ, 3'h2, 16'h0140, 7'h01);
        check("cs nack", 16'h1, {15'h0, nack});
        writeLock = 1'b1;
        wrBuf[0] = 8'h5A;
        cmd(OP_WRITE, 3'h5, 16'h0140, 7'h01);
        check("wp nack", 16'h0, {15'h0, nack});
        writeLock = 1'b0;
        waitIdle();
        cmd(OP_READ, 3'h5, 16'h0140, 7'h01);
        check("wp kept", 16'h00BB, {8'h0, rdBuf[0]});
        $display("test select and protect done");
        // id page write, read, lock, refused write
        wrBuf[0] = 8'hD1;
        wrBuf[1] = 8'hD2;
        cmd(OP_IDWRITE, 3'h5, 16'hFBC5, 7'h02);
        waitIdle();
        cmd(OP_IDREAD, 3'h5, 16'hFF05, 7'h02);
        check("id byte0", 16'h00D1, {8'h0, rdBuf[0]});
        check("id byte1", 16'h00D2, {8'h0, rdBuf[1]});
        cmd(OP_LOCK, 3'h5, 16'h0000, 7'h01);
        waitIdle();
        check("locked", 16'h1, {15'h0, idLocked});
        wrBuf[0] = 8'hE7;
        cmd(OP_IDWRITE, 3'h5, 16'h0005, 7'h01);
        check("locked nack", 16'h1, {15'h0, nack});
        waitIdle();
        cmd(OP_IDREAD, 3'h5, 16'h0005, 7'h01);
        check("id kept", 16'h00D1, {8'h0, rdBuf[0]});
        check("sda idle", 16'h1, {15'h0, linkIf.sda});
        $display("test id page done");
        close_out();
    end
endmodule
`default_nettype wire
